/* design/ratio_ctrl.sv */
// Divider setpoints, exact-ratio counter and shared status pin mux/driver.
// Assumes an SPI host on SCK/SEN/SDI; probes arrive asynchronous to CLK_IN.
//
// Contract
// - Reference divider takes up to 350MHz in, keeps comparison rate under 100MHz.
// - Integer mode feedback divide accepts 16 through 525287.
// - Fractional mode feedback divide accepts 20.0 through 242284.0.
// - Output divider supports even ratios only.
// - Overall ratio is feedback divide over reference times output divide.
// - Fraction is 24 bits; host computes floor and ceiling parts.
// - Correction counter loaded with reduced denominator gives exact ratio.
// - Correction counter is bits 13 to 0 of a 24-bit field.
// - Counter 0 or 1 disables correction, 2 to 16383 enables it.
// - Pin driver off after reset; without always-on, drives only during addressed reads.
// - Always-on bit 7 of pin control keeps driver enabled.
// - Codes 8-10 reference and divider outputs, 16-17 detector pulses.
// - Codes 20-25 internal strobes, 30 buffer enable, 31 soft reset.
// - Automux-prevent 0 alternates read data and signal; 1 signal only.
`timescale 1ns/1ps
`default_nettype none
module ratio_ctrl #(
  parameter int FRAME_BITS = ratio_pkg::SPI_FRAME_BITS
) (
  // Core clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              NRST_IN,
  // Serial host link
  input  wire logic              SCK_IN,
  input  wire logic              SEN_IN,
  input  wire logic              SDI_IN,
  // Shared status pin
  output logic                   STATUS_OUT,
  output logic                   STATUS_OE_OUT,
  // Internal probe sources
  input  wire ratio_pkg::probe_t PROBE_IN,
  input  wire logic              PFD_TICK_IN,
  // Divider setpoints
  output logic [13:0]            REF_DIV_OUT,
  output logic [19:0]            FEEDBACK_INT_OUT,
  output logic [23:0]            FEEDBACK_FRAC_OUT,
  output logic [6:0]             VCO_OUTPUT_DIVIDE_OUT,
  output logic                   FRAC_MODE_OUT,
  output logic                   RATIO_VALID_OUT,
  output logic                   FRAC_CARRY_OUT,
  output logic                   EXACT_ON_OUT
);
  // Frame position, cleared while SEN is low
  typedef struct packed {
    logic [5:0]  bitcnt;
    logic        rd_addr_ok;
  } frame_state_t;

  // Frame: bit0 write flag, 6 address bits, 24 data bits, msb first, plus one spare.
  typedef struct packed {
    logic [31:0] shreg;
    logic        wr_tog;
    ratio_pkg::spi_cmd_t cmd;
  } link_state_t;

  typedef struct packed {
    logic [23:0] refdiv;
    logic [23:0] nint;
    logic [23:0] nfrac;
    logic [23:0] vco_output_divide;
    logic [23:0] exact;
    logic [23:0] pinctl;
    logic [2:0]  tog_sync;
    logic [1:0]  rd_sync;
    logic        status;
    logic        oe;
    logic        valid;
    logic        frac_mode;
    logic        exact_on;
  } core_state_t;

  frame_state_t fr;
  frame_state_t next_fr;
  logic         frame_rst_n;
  link_state_t lk;
  link_state_t next_lk;
  core_state_t cs;
  core_state_t next_cs;
  ratio_pkg::probe_t probe_s1;
  ratio_pkg::probe_t probe_s2;
  logic        sel_bit;
  logic        ratio_ok;
  logic [19:0] nint_val;
  logic        carry;
  logic        exact_on;

  function automatic logic addr_known(input logic [5:0] a);
    addr_known = (a == ratio_pkg::ADDR_REFDIV) || (a == ratio_pkg::ADDR_NINT) ||
                 (a == ratio_pkg::ADDR_NFRAC)  || (a == ratio_pkg::ADDR_VCO_OUTPUT_DIVIDE) ||
                 (a == ratio_pkg::ADDR_EXACT)  || (a == ratio_pkg::ADDR_PINCTL);
  endfunction

  function automatic logic in_range(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  // Link domain: shift register on SCK, frame position cleared by SEN dropping
  assign frame_rst_n = NRST_IN & SEN_IN;

  always_comb begin
    next_lk = lk;
    next_fr = fr;
    next_lk.shreg  = {lk.shreg[30:0], SDI_IN};
    next_fr.bitcnt = fr.bitcnt + 6'h01;
    if (fr.bitcnt == ratio_pkg::ADDR_LAST_EDGE) begin
      // Read address known after 7 bits: flag + 6 address bits
      next_fr.rd_addr_ok = ~lk.shreg[5] && addr_known({lk.shreg[4:0], SDI_IN});
      next_lk.cmd.addr   = {lk.shreg[4:0], SDI_IN};
    end
    if (fr.bitcnt == 6'(FRAME_BITS - 2)) begin
      next_lk.cmd.write = lk.shreg[29];
      next_lk.cmd.data  = {lk.shreg[22:0], SDI_IN};
      if (lk.shreg[29]) begin
        next_lk.wr_tog = ~lk.wr_tog;
      end
    end
  end

  always_ff @(posedge SCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // SEN low holds the frame position at zero, so a cut frame cannot skew the next
  always_ff @(posedge SCK_IN or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // Read data shift: sampled registers are quasi-static during a read frame
  logic [23:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (lk.cmd.addr == ratio_pkg::ADDR_REFDIV) begin
      rd_word = cs.refdiv;
    end else if (lk.cmd.addr == ratio_pkg::ADDR_NINT) begin
      rd_word = cs.nint;
    end else if (lk.cmd.addr == ratio_pkg::ADDR_NFRAC) begin
      rd_word = cs.nfrac;
    end else if (lk.cmd.addr == ratio_pkg::ADDR_VCO_OUTPUT_DIVIDE) begin
      rd_word = cs.vco_output_divide;
    end else if (lk.cmd.addr == ratio_pkg::ADDR_EXACT) begin
      rd_word = cs.exact;
    end else if (lk.cmd.addr == ratio_pkg::ADDR_PINCTL) begin
      rd_word = cs.pinctl;
    end
  end

  logic [23:0] rd_shift;
  logic        rd_bit;
  always_ff @(negedge SCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_shift <= '0;
    end else if (fr.bitcnt == ratio_pkg::RD_LOAD_EDGE) begin
      rd_shift <= rd_word;
    end else begin
      rd_shift <= {rd_shift[22:0], 1'b0};
    end
  end
  assign rd_bit = rd_shift[23];

  // Probe inputs are asynchronous to the core clock
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      probe_s1 <= '0;
      probe_s2 <= '0;
    end else begin
      probe_s1 <= PROBE_IN;
      probe_s2 <= probe_s1;
    end
  end

  // Status signal select
  always_comb begin
    case (cs.pinctl[ratio_pkg::SEL_W-1:0])
      5'h00: sel_bit = cs.pinctl[ratio_pkg::BIT_TESTDATA];
      5'h01: sel_bit = probe_s2.lock_detect;
      5'h02: sel_bit = probe_s2.lock_trigger;
      5'h03: sel_bit = probe_s2.lock_window;
      5'h08: sel_bit = probe_s2.ref_buf;
      5'h09: sel_bit = probe_s2.ref_div;
      5'h0a: sel_bit = probe_s2.vco_div;
      5'h10: sel_bit = probe_s2.pd_dn;
      5'h11: sel_bit = probe_s2.pd_up;
      5'h14: sel_bit = probe_s2.int_write;
      5'h15: sel_bit = probe_s2.frac_write;
      5'h16: sel_bit = probe_s2.aux_write;
      5'h17: sel_bit = probe_s2.latch_en;
      5'h18: sel_bit = probe_s2.sync_reset;
      5'h19: sel_bit = probe_s2.seed_load;
      5'h1e: sel_bit = cs.oe;
      5'h1f: sel_bit = probe_s2.soft_reset;
      default: sel_bit = 1'b0;
    endcase
  end

  // Range checks on the divider setpoints
  assign nint_val = cs.nint[ratio_pkg::NINT_W-1:0];
  always_comb begin
    if (cs.nfrac[ratio_pkg::FRAC_W-1:0] == '0) begin
      ratio_ok = in_range(nint_val, ratio_pkg::NINT_MIN, ratio_pkg::NINT_MAX);
    end else begin
      // Any fraction on top of the ceiling integer would pass the limit
      ratio_ok = in_range(nint_val, ratio_pkg::NFRAC_MIN, ratio_pkg::NFRAC_MAX) &&
                 (nint_val != ratio_pkg::NFRAC_MAX);
    end
    // Odd output divide values are rejected, not rounded
    ratio_ok = ratio_ok && !cs.vco_output_divide[0] && (cs.vco_output_divide[ratio_pkg::VCO_OUTPUT_DIVIDE_W-1:0] != '0);
    ratio_ok = ratio_ok && (cs.refdiv[ratio_pkg::REF_W-1:0] != '0);
  end

  // Core domain: write toggle crossing and pin driver
  always_comb begin
    next_cs = cs;
    next_cs.tog_sync = {cs.tog_sync[1:0], lk.wr_tog};
    next_cs.rd_sync  = {cs.rd_sync[0], fr.rd_addr_ok};
    if (cs.tog_sync[2] != cs.tog_sync[1]) begin
      // Command word is stable: its address changes after 7 bits of the next frame, its data at that frame's end
      if (lk.cmd.addr == ratio_pkg::ADDR_REFDIV) begin
        next_cs.refdiv = lk.cmd.data;
      end else if (lk.cmd.addr == ratio_pkg::ADDR_NINT) begin
        next_cs.nint = lk.cmd.data;
      end else if (lk.cmd.addr == ratio_pkg::ADDR_NFRAC) begin
        next_cs.nfrac = lk.cmd.data;
      end else if (lk.cmd.addr == ratio_pkg::ADDR_VCO_OUTPUT_DIVIDE) begin
        next_cs.vco_output_divide = lk.cmd.data;
      end else if (lk.cmd.addr == ratio_pkg::ADDR_EXACT) begin
        next_cs.exact = 24'(lk.cmd.data[ratio_pkg::EXACT_W-1:0]);
      end else if (lk.cmd.addr == ratio_pkg::ADDR_PINCTL) begin
        next_cs.pinctl = lk.cmd.data;
      end
    end
    // Status levels leave through flops like the setpoints
    next_cs.valid     = ratio_ok;
    next_cs.frac_mode = cs.nfrac != '0;
    next_cs.exact_on  = exact_on;
    next_cs.oe = cs.pinctl[ratio_pkg::BIT_ALWAYS_ON] | cs.rd_sync[1];
    if (cs.pinctl[ratio_pkg::BIT_AUTOMUX] || !cs.rd_sync[1]) begin
      next_cs.status = sel_bit;
    end else begin
      next_cs.status = rd_bit;
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cs.refdiv    <= ratio_pkg::REFDIV_RESET;
      cs.nint      <= ratio_pkg::NINT_RESET;
      cs.nfrac     <= ratio_pkg::NFRAC_RESET;
      cs.vco_output_divide      <= ratio_pkg::VCO_OUTPUT_DIVIDE_RESET;
      cs.exact     <= ratio_pkg::EXACT_RESET;
      cs.pinctl    <= ratio_pkg::PINCTL_RESET;
      cs.tog_sync  <= '0;
      cs.rd_sync   <= '0;
      cs.status    <= 1'b0;
      cs.oe        <= 1'b0;
      cs.valid     <= 1'b0;
      cs.frac_mode <= 1'b0;
      cs.exact_on  <= 1'b0;
    end else begin
      cs <= next_cs;
    end
  end

  frac_accum u_accum (
    .clk_in       (CLK_IN),
    .nrst_in      (NRST_IN),
    .tick_in      (PFD_TICK_IN),
    .frac_in      (cs.nfrac[ratio_pkg::FRAC_W-1:0]),
    .exact_in     (cs.exact[ratio_pkg::EXACT_W-1:0]),
    .carry_out    (carry),
    .exact_on_out (exact_on)
  );

  // Ratio = feedback / (reference * output); setpoints drive the three dividers
  assign REF_DIV_OUT           = cs.refdiv[ratio_pkg::REF_W-1:0];
  assign FEEDBACK_INT_OUT      = nint_val;
  assign FEEDBACK_FRAC_OUT     = cs.nfrac;
  assign VCO_OUTPUT_DIVIDE_OUT = cs.vco_output_divide[ratio_pkg::VCO_OUTPUT_DIVIDE_W-1:0];
  assign FRAC_MODE_OUT         = cs.frac_mode;
  assign RATIO_VALID_OUT       = cs.valid;
  assign FRAC_CARRY_OUT        = carry;
  assign EXACT_ON_OUT          = cs.exact_on;
  assign STATUS_OUT            = cs.status;
  assign STATUS_OE_OUT         = cs.oe;
endmodule
`default_nettype wire

/* design/ratio_pkg.sv */
// Shared constants and carriers for the divider setpoints and status pin mux.
// Assumes an SPI-style 24-bit register write/read path clocked by the link clock.
package ratio_pkg;
  localparam int          DATA_W         = 24;
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  ADDR_REFDIV    = 6'h02;
  localparam logic [5:0]  ADDR_NINT      = 6'h03;
  localparam logic [5:0]  ADDR_NFRAC     = 6'h04;
  localparam logic [5:0]  ADDR_VCO_OUTPUT_DIVIDE      = 6'h06;
  localparam logic [5:0]  ADDR_EXACT     = 6'h0c;
  localparam logic [5:0]  ADDR_PINCTL    = 6'h0f;
  localparam logic [23:0] EXACT_RESET    = 24'h000000;
  localparam logic [23:0] PINCTL_RESET   = 24'h000001;
  localparam logic [23:0] REFDIV_RESET   = 24'h000001;
  localparam logic [23:0] NINT_RESET     = 24'h000019;
  localparam logic [23:0] NFRAC_RESET    = 24'h000000;
  localparam logic [23:0] VCO_OUTPUT_DIVIDE_RESET     = 24'h000002;
  localparam int          EXACT_W        = 14;
  localparam int          SEL_W          = 5;
  localparam int          FRAC_W         = 24;
  localparam int          NINT_W         = 20;
  localparam int          REF_W          = 14;
  localparam int          VCO_OUTPUT_DIVIDE_W         = 7;
  localparam int          BIT_TESTDATA   = 5;
  localparam int          BIT_AUTOMUX    = 6;
  localparam int          BIT_ALWAYS_ON  = 7;
  localparam logic [19:0] NINT_MIN       = 20'h00010;
  localparam logic [19:0] NINT_MAX       = 20'h803e7;
  localparam logic [19:0] NFRAC_MIN      = 20'h00014;
  localparam logic [19:0] NFRAC_MAX      = 20'h3b26c;
  localparam logic [13:0] EXACT_MIN_ON   = 14'h0002;
  localparam int          SPI_FRAME_BITS = 32;
  localparam logic [5:0]  ADDR_LAST_EDGE = 6'h06;
  localparam logic [5:0]  RD_LOAD_EDGE   = 6'h07;

  typedef struct packed {
    logic       write;
    logic [5:0] addr;
    logic [23:0] data;
  } spi_cmd_t;

  typedef struct packed {
    logic lock_detect;
    logic lock_trigger;
    logic lock_window;
    logic ref_buf;
    logic ref_div;
    logic vco_div;
    logic pd_dn;
    logic pd_up;
    logic int_write;
    logic frac_write;
    logic aux_write;
    logic latch_en;
    logic sync_reset;
    logic seed_load;
    logic soft_reset;
  } probe_t;
endpackage

/* design/frac_accum.sv */
// Fractional divider phase accumulator with exact-ratio periodic correction.
// Assumes one comparison-rate tick per CLK_IN cycle enable; runs on core clock.
`timescale 1ns/1ps
`default_nettype none
module frac_accum #(
  parameter int FRAC_W  = ratio_pkg::FRAC_W,
  parameter int EXACT_W = ratio_pkg::EXACT_W
) (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire logic               tick_in,
  input  wire logic [FRAC_W-1:0]  frac_in,
  input  wire logic [EXACT_W-1:0] exact_in,
  output logic                    carry_out,
  output logic                    exact_on_out
);
  typedef struct packed {
    logic [FRAC_W-1:0]  acc;
    logic [EXACT_W-1:0] cnt;
    logic               carry;
  } acc_state_t;

  acc_state_t st;
  acc_state_t next_st;
  logic       exact_on;
  logic [FRAC_W:0] sum;

  assign exact_on = exact_in >= ratio_pkg::EXACT_MIN_ON;

  always_comb begin
    next_st = st;
    sum = {1'b0, st.acc} + {1'b0, frac_in};
    if (tick_in) begin
      next_st.acc   = sum[FRAC_W-1:0];
      next_st.carry = sum[FRAC_W];
      if (exact_on) begin
        // Restart the phase every period so quantization never accumulates
        if (st.cnt >= exact_in - EXACT_W'(1)) begin
          next_st.cnt = '0;
          next_st.acc = '0;
        end else begin
          next_st.cnt = st.cnt + EXACT_W'(1);
        end
      end else begin
        next_st.cnt = '0;
      end
    end else begin
      next_st.carry = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign carry_out    = st.carry;
  assign exact_on_out = exact_on;
endmodule
`default_nettype wire

/* test/ratio_monitor.sv */
// Port checker for the ratio control block.
// Assumes setpoint outputs settle within two CLK_IN cycles.
`timescale 1ns/1ps
`default_nettype none
module ratio_monitor (
  // Clock and reset
  input wire logic        CLK_IN,
  input wire logic        NRST_IN,
  // Watched outputs
  input wire logic        STATUS_OE_OUT,
  input wire logic [13:0] REF_DIV_OUT,
  input wire logic [19:0] FEEDBACK_INT_OUT,
  input wire logic [23:0] FEEDBACK_FRAC_OUT,
  input wire logic [6:0]  VCO_OUTPUT_DIVIDE_OUT,
  input wire logic        FRAC_MODE_OUT,
  input wire logic        RATIO_VALID_OUT,
  input wire logic        FRAC_CARRY_OUT,
  input wire logic        EXACT_ON_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  logic int_ok;
  logic frac_ok;
  logic set_ok;
  logic frac_nz;
  assign frac_nz = FEEDBACK_FRAC_OUT != 24'h000000;
  assign int_ok = FEEDBACK_INT_OUT >= 20'h00010 && FEEDBACK_INT_OUT <= 20'h803e7;
  assign frac_ok = FEEDBACK_INT_OUT >= 20'h00014 && FEEDBACK_INT_OUT <= 20'h3b26b;
  assign set_ok = REF_DIV_OUT != 14'h0000 && VCO_OUTPUT_DIVIDE_OUT != 7'h00
    && !VCO_OUTPUT_DIVIDE_OUT[0] && (frac_nz ? frac_ok : int_ok);
  reset_vals_a: assert property ($rose(NRST_IN) |-> !STATUS_OE_OUT && !EXACT_ON_OUT
    && REF_DIV_OUT == 14'h0001 && FEEDBACK_INT_OUT == 20'h00019 && VCO_OUTPUT_DIVIDE_OUT == 7'h02)
    else $error("reset setpoints wrong");
  frac_on_a: assert property (frac_nz [*3] |-> FRAC_MODE_OUT)
    else $error("fraction mode missing");
  frac_off_a: assert property (!frac_nz [*3] |-> !FRAC_MODE_OUT)
    else $error("fraction mode stuck");
  int_low_a: assert property ((!frac_nz && FEEDBACK_INT_OUT < 20'h00010) [*3] |-> !RATIO_VALID_OUT)
    else $error("integer below minimum accepted");
  int_high_a: assert property ((!frac_nz && FEEDBACK_INT_OUT > 20'h803e7) [*3] |-> !RATIO_VALID_OUT)
    else $error("integer above maximum accepted");
  frac_low_a: assert property ((frac_nz && FEEDBACK_INT_OUT < 20'h00014) [*3] |-> !RATIO_VALID_OUT)
    else $error("fractional ratio below minimum accepted");
  frac_high_a: assert property ((frac_nz && FEEDBACK_INT_OUT > 20'h3b26b) [*3] |-> !RATIO_VALID_OUT)
    else $error("fractional ratio above maximum accepted");
  odd_div_a: assert property (VCO_OUTPUT_DIVIDE_OUT[0] [*3] |-> !RATIO_VALID_OUT)
    else $error("odd output divide accepted");
  ratio_ok_a: assert property (set_ok [*3] |-> RATIO_VALID_OUT)
    else $error("legal setpoints refused");
  no_carry_a: assert property ((!frac_nz && !EXACT_ON_OUT) [*3] |-> !FRAC_CARRY_OUT)
    else $error("carry without fraction");
  cover property ($rose(STATUS_OE_OUT));
  cover property ($rose(EXACT_ON_OUT));
  cover property (FRAC_CARRY_OUT);
endmodule
bind ratio_ctrl ratio_monitor mon (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .STATUS_OE_OUT(STATUS_OE_OUT),
  .REF_DIV_OUT(REF_DIV_OUT), .FEEDBACK_INT_OUT(FEEDBACK_INT_OUT), .FEEDBACK_FRAC_OUT(FEEDBACK_FRAC_OUT),
  .VCO_OUTPUT_DIVIDE_OUT(VCO_OUTPUT_DIVIDE_OUT), .FRAC_MODE_OUT(FRAC_MODE_OUT),
  .RATIO_VALID_OUT(RATIO_VALID_OUT), .FRAC_CARRY_OUT(FRAC_CARRY_OUT), .EXACT_ON_OUT(EXACT_ON_OUT));
`default_nettype wire

/* test/host_spi_model.sv */
// Serial host model sending 32-bit frames into the block.
// Assumes the bench calls xfer; serial clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
  // Serial host link
  output var logic  SCK_OUT,
  output var logic  SEN_OUT,
  output var logic  SDI_OUT,
  // Shared status pin
  input  wire logic STATUS_IN,
  input  wire logic STATUS_OE_IN
);
  // Last read word as seen on the pin
  logic [23:0] rd_data;
  initial begin
    rd_data = '0;
    SCK_OUT = 1'b0;
    SEN_OUT = 1'b0;
    SDI_OUT = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [5:0] addr, input logic [23:0] data);
    logic [31:0] word;
    word = {wr, addr, data, 1'b0};
    #13;
    SEN_OUT = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      SDI_OUT = word[i];
      #40 SCK_OUT = 1'b1;
      #20;
      // Undriven pin reads inverted, so a late driver turn-on shows up
      if (i >= 1 && i <= 24) begin
        rd_data[i-1] = STATUS_OE_IN ? STATUS_IN : ~STATUS_IN;
      end
      #20 SCK_OUT = 1'b0;
    end
    #40 SEN_OUT = 1'b0;
    // Released line must not look valid
    SDI_OUT = ~SDI_OUT;
    #400;
  endtask
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the ratio control block.
// Assumes the host model frames and a 25 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [5:0] A_REF = ratio_pkg::ADDR_REFDIV;
  localparam logic [5:0] A_INT = ratio_pkg::ADDR_NINT;
  localparam logic [5:0] A_FRC = ratio_pkg::ADDR_NFRAC;
  localparam logic [5:0] A_OUT = ratio_pkg::ADDR_VCO_OUTPUT_DIVIDE;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sck, sen, sdi, status, status_oe, frac_mode, valid, carry, exact_on;
  logic tick = 1'b0;
  ratio_pkg::probe_t probe;
  logic [13:0] ref_div;
  logic [19:0] fb_int;
  logic [23:0] fb_frac;
  logic [6:0] vco_output_divide;
  int error_cnt = 0;
  int comparisons = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  host_spi_model host (.SCK_OUT(sck), .SEN_OUT(sen), .SDI_OUT(sdi), .STATUS_IN(status),
    .STATUS_OE_IN(status_oe));
  ratio_ctrl dut (.CLK_IN(clk), .NRST_IN(nrst), .SCK_IN(sck), .SEN_IN(sen), .SDI_IN(sdi),
    .STATUS_OUT(status), .STATUS_OE_OUT(status_oe), .PROBE_IN(probe), .PFD_TICK_IN(tick),
    .REF_DIV_OUT(ref_div), .FEEDBACK_INT_OUT(fb_int), .FEEDBACK_FRAC_OUT(fb_frac),
    .VCO_OUTPUT_DIVIDE_OUT(vco_output_divide), .FRAC_MODE_OUT(frac_mode), .RATIO_VALID_OUT(valid),
    .FRAC_CARRY_OUT(carry), .EXACT_ON_OUT(exact_on));
  always @(negedge clk) tick <= ~tick;
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic t_exact;
    logic [23:0] v [6] = '{24'h0, 24'h1, 24'h2, 24'h3fff, 24'hff, 24'hffc001};
    logic e [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      host.xfer(1'b1, ratio_pkg::ADDR_EXACT, v[i]);
      chk("exact_on", 24'(e[i]), 24'(exact_on));
    end
    $display("test exact done");
  endtask
  task automatic t_range;
    logic [5:0] a [15] = '{A_REF, A_REF, A_INT, A_INT, A_INT, A_INT, A_INT, A_FRC, A_INT, A_OUT, A_OUT, A_FRC,
      A_FRC, A_INT, A_INT};
    logic [23:0] d [15] = '{24'h0, 24'h3, 24'h10, 24'hf, 24'h803e7, 24'h803e8, 24'h13, 24'h6c6c6c,
      24'h14, 24'h3, 24'h4, 24'h0, 24'h1, 24'h3b26c, 24'h3b26b};
    logic ok [15] = '{0, 1, 1, 0, 1, 0, 1, 0, 1, 0, 1, 1, 1, 0, 1};
    logic fm [15] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 0, 1, 1, 1};
    logic [23:0] got;
    for (int i = 0; i < 15; i++) begin
      host.xfer(1'b1, a[i], d[i]);
      got = a[i] == A_REF ? 24'(ref_div) : a[i] == A_INT ? 24'(fb_int) : a[i] == A_FRC ? fb_frac : 24'(vco_output_divide);
      chk("setpoint", d[i], got);
      chk("ratio_valid", 24'(ok[i]), 24'(valid));
      chk("frac_mode", 24'(fm[i]), 24'(frac_mode));
    end
    $display("test range done");
  endtask
  task automatic t_mux;
    logic [23:0] d [18] = '{24'hc1, 24'hc2, 24'hc3, 24'hc8, 24'hc9, 24'hca, 24'hd0, 24'hd1, 24'hd4,
      24'hd5, 24'hd6, 24'hd7, 24'hd8, 24'hd9, 24'hdf, 24'hc7, 24'he0, 24'hc0};
    int b [18] = '{14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 15, 15, 15};
    logic [14:0] pv;
    for (int i = 0; i < 18; i++) begin
      host.xfer(1'b1, ratio_pkg::ADDR_PINCTL, d[i]);
      for (int v = 0; v < 2; v++) begin
        pv = 15'h1 << b[i];
        @(negedge clk) probe = ratio_pkg::probe_t'(v == 1 ? pv : ~pv);
        repeat (8) @(negedge clk);
        chk("status", b[i] < 15 ? 24'(v) : 24'(d[i][5]), 24'(status));
        chk("status_oe", 24'h1, 24'(status_oe));
      end
    end
    $display("test mux done");
  endtask
  task automatic rd(input logic [5:0] a, input logic oe_exp, input logic low_exp);
    logic oe_seen;
    logic low_seen;
    oe_seen = 1'b0;
    low_seen = 1'b0;
    fork
      host.xfer(1'b0, a, 24'h0);
      repeat (75) @(negedge clk) begin
        oe_seen |= status_oe === 1'b1;
        low_seen |= status_oe === 1'b1 && status === 1'b0;
      end
    join
    chk("read_drive", 24'(oe_exp), 24'(oe_seen));
    chk("read_low", 24'(low_exp), 24'(low_seen));
    chk("idle_oe", 24'h0, 24'(status_oe));
  endtask
  task automatic t_read;
    @(negedge clk) probe = ratio_pkg::probe_t'(15'h7fff);
    host.xfer(1'b1, ratio_pkg::ADDR_PINCTL, 24'h000001);
    chk("oe_off", 24'h0, 24'(status_oe));
    rd(ratio_pkg::ADDR_EXACT, 1'b1, 1'b1);
    chk("read_data", 24'h000001, 24'(host.rd_data[22:0]));
    host.xfer(1'b1, ratio_pkg::ADDR_PINCTL, 24'h000041);
    rd(ratio_pkg::ADDR_EXACT, 1'b1, 1'b0);
    rd(6'h3f, 1'b0, 1'b0);
    $display("test read done");
  endtask
  initial begin
    probe = ratio_pkg::probe_t'(15'h0);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("reset_oe", 24'h0, 24'(status_oe));
    chk("reset_status", 24'h0, 24'(status));
    $display("test reset done");
    t_exact();
    t_range();
    t_mux();
    t_read();
    end_of_test();
  end
  // Roughly 45 frames of 3 us each are expected
  initial begin
    #500000;
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    end_of_test();
  end
endmodule
`default_nettype wire
